// ### hw/btnev_debounce.sv
/*
  btnev_debounce: three-flop synchroniser plus stability filter for one push button.
  assumes: i_key_n is an asynchronous active-low pin; i_tick is a one-cycle slow enable.
*/
`timescale 1ns/10ps
module btnev_debounce #(
  parameter int unsigned STABLE_TICKS = btnev_pkg::DEBOUNCE_TICKS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_key_n,
  output logic      o_level,
  output logic      o_press
);
  import btnev_pkg::*;

  localparam int unsigned CW = $clog2(STABLE_TICKS + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          s3;
    logic [CW-1:0] cnt;
    logic          level;
    logic          press;
  } btnev_db_type;

  btnev_db_type st_q;
  btnev_db_type st_d;

  // a change only counts while stages two and three agree, then must hold for the full time
  always_comb begin
    st_d       = st_q;
    st_d.s1    = ~i_key_n;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.press = 1'b0;
    if ((st_q.s2 != st_q.s3) || (st_q.s3 == st_q.level)) begin
      st_d.cnt = '0;
    end else if (i_tick) begin
      if (st_q.cnt >= CW'(STABLE_TICKS - 1)) begin
        st_d.cnt   = '0;
        st_d.level = st_q.s3;
        st_d.press = st_q.s3; // RULE4 RULE10 RULE18
      end else begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.level;
  assign o_press = st_q.press;

endmodule : btnev_debounce

// ### hw/btnev_pkg.sv
/*
  btnev_pkg: constants and types shared by the button event logic.
  assumes: a single 50 MHz core clock; times are converted to ticks of a slow enable.
*/
package btnev_pkg;

  // core clock and slow tick timing
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned SLOW_TICK_US      = 1000;
  localparam int unsigned SLOW_TICK_CYCLES  = (SLOW_TICK_US * 1000) / CLK_PERIOD_NS;

  // debounce stability time and override hold time, in slow ticks
  localparam int unsigned DEBOUNCE_TIME_MS  = 20;
  localparam int unsigned DEBOUNCE_TICKS    = (DEBOUNCE_TIME_MS * 1000) / SLOW_TICK_US;
  localparam int unsigned OVERRIDE_TIME_MS  = 4000;
  localparam int unsigned OVERRIDE_TICKS    = (OVERRIDE_TIME_MS * 1000) / SLOW_TICK_US;

  // control-method status byte in i/o space
  localparam logic [15:0] METHOD_BYTE_ADDR  = 16'h0200;
  localparam int unsigned PRESS_REQ_POS     = 0;
  localparam int unsigned WAKE_REQ_POS      = 1;
  localparam logic [7:0]  METHOD_BYTE_RESET = 8'h00;

  // global system state, gray coded along working -> sleeping -> soft-off
  typedef enum logic [1:0] {
    BTNEV_WORKING  = 2'b00,
    BTNEV_SLEEPING = 2'b01,
    BTNEV_SOFT_OFF = 2'b11
  } btnev_sys_type;

endpackage : btnev_pkg

// ### hw/btnev_top.sv
/*
  btnev_top: power and sleep button event logic with override and control-method byte.
  assumes: the platform supplies the global state, the enable flags, clear strobes and
  the sleep-entry trigger level; sequencing to soft-off is done by logic outside.
*/
// Behaviour
// RULE1: every debounced power key press sets the power status flag.
// RULE2: interrupt while power enable set and status set by a working-state press.
// RULE3: status flags stay set until software clears them after service.
// RULE4: power key is debounced; status set once on the press edge.
// RULE5: press while sleeping or soft-off sets status and wakes, enable ignored.
// RULE6: key held four seconds in working state raises the override event.
// RULE7: override clears the power status flag in hardware.
// RULE8: every debounced sleep key press sets the sleep status flag.
// RULE9: interrupt while sleep enable set and status set by a working-state press.
// RULE10: sleep key is debounced; status set once on the press edge.
// RULE11: sleep press while sleeping sets status; wakes only if sleep trigger set.
// RULE12: platform reports power key model through method flag and device object.
// RULE13: platform encodes sleep key support through its flag and object presence.
// RULE14: method byte status bits clear on writing one; zeros leave them alone.
// RULE15: method byte holds press request bit 0, wake request bit 1, to event 0.
// RULE16: event handler clears press bit and notifies with code 0x80 or 0x2.
// RULE17: override goes out on a dedicated signal to the sleep/wake sequencer.
// RULE18: debounce accepts a change only after a configurable stable tick count.
// RULE19: hold time counted on slow ticks, restarting whenever the key is released.
`timescale 1ns/10ps
module btnev_top #(
  parameter int unsigned TICK_CYCLES   = btnev_pkg::SLOW_TICK_CYCLES,
  parameter int unsigned DEBOUNCE_TKS  = btnev_pkg::DEBOUNCE_TICKS,
  parameter int unsigned OVERRIDE_TKS  = btnev_pkg::OVERRIDE_TICKS
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_power_key_n,
  input  wire logic                   i_sleep_key_n,
  input  wire btnev_pkg::btnev_sys_type i_sys_state,
  input  wire logic                   i_power_key_enable_flag,
  input  wire logic                   i_sleep_key_enable_flag,
  input  wire logic                   i_power_key_status_clr,
  input  wire logic                   i_sleep_key_status_clr,
  input  wire logic                   i_sleep_entry_trigger,
  input  wire logic [15:0]            i_io_addr,
  input  wire logic                   i_io_wr,
  input  wire logic [7:0]             i_io_wdata,
  output logic [7:0]                  o_io_rdata,
  output logic                        o_power_key_status_flag,
  output logic                        o_sleep_key_status_flag,
  output logic                        o_system_control_interrupt,
  output logic                        o_gpe0_status_bit0,
  output logic                        o_wake,
  output logic                        o_power_key_override_signal
);
  import btnev_pkg::*;

  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned HW = $clog2(OVERRIDE_TKS + 1);

  typedef struct packed {
    logic [DW-1:0] div;
    logic          tick;
    logic [HW-1:0] hold;
    logic          fired;
    logic          pwr_sts;
    logic          pwr_g0;
    logic          slp_sts;
    logic          slp_g0;
    logic          press_req;
    logic          wake_req;
    logic          system_control_interrupt;
    logic          wake;
    logic          ovr;
    logic [7:0]    rdata;
  } btnev_st_type;

  btnev_st_type st_q;
  btnev_st_type st_d;

  logic pwr_level;
  logic pwr_press;
  logic slp_level;
  logic slp_press;

  // per-button synchroniser and filter, both on the shared slow tick
  btnev_debounce #(.STABLE_TICKS(DEBOUNCE_TKS)) u_pwr_db (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (st_q.tick),
    .i_key_n (i_power_key_n),
    .o_level (pwr_level),
    .o_press (pwr_press)
  );

  btnev_debounce #(.STABLE_TICKS(DEBOUNCE_TKS)) u_slp_db (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (st_q.tick),
    .i_key_n (i_sleep_key_n),
    .o_level (slp_level),
    .o_press (slp_press)
  );

  // decode of the system state, used by both buttons
  function automatic logic is_working(input btnev_sys_type s);
    case (s)
      BTNEV_WORKING:  is_working = 1'b1;
      BTNEV_SLEEPING: is_working = 1'b0;
      BTNEV_SOFT_OFF: is_working = 1'b0;
      default:        is_working = 1'b0;
    endcase
  endfunction : is_working

  logic working;
  logic sleeping;
  logic byte_wr;
  logic ovr_now;

  assign working  = is_working(i_sys_state);
  assign sleeping = (i_sys_state == BTNEV_SLEEPING);
  assign byte_wr  = i_io_wr && (i_io_addr == METHOD_BYTE_ADDR);

  // next-state logic; every set term is applied after its clear so an event is never lost
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    st_d.wake = 1'b0;
    st_d.ovr  = 1'b0;
    ovr_now   = 1'b0;

    // slow tick divider
    if (st_q.div >= DW'(TICK_CYCLES - 1)) begin
      st_d.div  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + DW'(1);
    end

    // hold counter restarts on release and outside the working state
    if (!pwr_level || !working) begin
      st_d.hold  = '0; // RULE19
      st_d.fired = 1'b0;
    end else if (st_q.tick && !st_q.fired) begin
      if (st_q.hold >= HW'(OVERRIDE_TKS - 1)) begin
        ovr_now    = 1'b1; // RULE6
        st_d.fired = 1'b1; // one override per hold, not a stream
      end else begin
        st_d.hold = st_q.hold + HW'(1);
      end
    end
    st_d.ovr = ovr_now; // RULE17

    // software and override clears of the fixed-hardware flags
    if (i_power_key_status_clr) begin
      st_d.pwr_sts = 1'b0; // RULE3
      st_d.pwr_g0  = 1'b0;
    end
    if (i_sleep_key_status_clr) begin
      st_d.slp_sts = 1'b0; // RULE3
      st_d.slp_g0  = 1'b0;
    end
    if (ovr_now) begin
      st_d.pwr_sts = 1'b0; // RULE7
      st_d.pwr_g0  = 1'b0;
    end

    // write-one-to-clear on the method byte, zero bits leave state alone
    if (byte_wr && i_io_wdata[PRESS_REQ_POS]) begin
      st_d.press_req = 1'b0; // RULE14
    end
    if (byte_wr && i_io_wdata[WAKE_REQ_POS]) begin
      st_d.wake_req = 1'b0; // RULE14
    end

    // power key press: sets status always, wakes when not working
    if (pwr_press) begin
      st_d.pwr_sts = 1'b1; // RULE1
      if (working) begin
        st_d.pwr_g0    = 1'b1;
        st_d.press_req = 1'b1; // RULE15
      end else begin
        st_d.wake     = 1'b1; // RULE5
        st_d.wake_req = 1'b1; // RULE15
      end
    end

    // sleep key press: sets status always, wakes from sleep only with the trigger set
    if (slp_press) begin
      st_d.slp_sts = 1'b1; // RULE8
      if (working) begin
        st_d.slp_g0 = 1'b1;
      end else if (sleeping && i_sleep_entry_trigger) begin
        st_d.wake = 1'b1; // RULE11
      end
    end

    // interrupt only for working-state presses; power presses outside working and triggered sleeping sleep presses wake instead
    st_d.system_control_interrupt = (i_power_key_enable_flag && st_d.pwr_sts && st_d.pwr_g0)   // RULE2
            || (i_sleep_key_enable_flag && st_d.slp_sts && st_d.slp_g0);  // RULE9

    // registered read of the method byte; unmapped addresses read as zero
    st_d.rdata = 8'h00;
    if (i_io_addr == METHOD_BYTE_ADDR) begin
      st_d.rdata[PRESS_REQ_POS] = st_q.press_req;
      st_d.rdata[WAKE_REQ_POS]  = st_q.wake_req;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= '0;
      st_q.rdata <= METHOD_BYTE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_io_rdata                  = st_q.rdata;
  assign o_power_key_status_flag     = st_q.pwr_sts;
  assign o_sleep_key_status_flag     = st_q.slp_sts;
  assign o_system_control_interrupt  = st_q.system_control_interrupt;
  assign o_gpe0_status_bit0          = st_q.press_req | st_q.wake_req; // RULE15
  assign o_wake                      = st_q.wake;
  assign o_power_key_override_signal = st_q.ovr;

  // slp_level is kept for symmetry; the sleep key has no hold function
  logic unused_slp_level;
  assign unused_slp_level = slp_level;

endmodule : btnev_top

// ### test/btnev_keys_model.sv
/* btnev_keys_model: two pulled-up push buttons with contact chatter.
   assumes: bench raises a down command per key. */
`timescale 1ns/10ps
module btnev_keys_model (
  input  wire logic i_clk,
  input  wire logic i_power_down,
  input  wire logic i_sleep_down,
  input  wire logic i_bounce,
  output logic      o_power_key_n,
  output logic      o_sleep_key_n
);
  // platform reports both keys as fixed hardware: method flags clear, no device objects
  localparam logic POWER_KEY_METHOD_FLAG = 1'b0;
  localparam logic SLEEP_KEY_METHOD_FLAG = 1'b0;
  logic [2:0] chat_q = 3'h0;
  // chatter shorter than the stable time, so a sound filter sees one press
  always @(posedge i_clk) begin
    if (!(i_power_down || i_sleep_down)) chat_q <= 3'h0;
    else if (chat_q != 3'h7) chat_q <= chat_q + 3'h1;
  end
  wire logic flip = i_bounce && chat_q != 3'h7 && chat_q[0];
  // only a fixed-hardware key is wired to the event pins; a method key would sit elsewhere
  assign o_power_key_n = !(i_power_down && !flip && !POWER_KEY_METHOD_FLAG);
  assign o_sleep_key_n = !(i_sleep_down && !flip && !SLEEP_KEY_METHOD_FLAG);
endmodule : btnev_keys_model

// ### test/btnev_top_asserts.sv
/* btnev_top_asserts: port checks for btnev_top.
   assumes: bound into btnev_top; one clock, async active-low reset. */
`timescale 1ns/10ps
module btnev_top_asserts (
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  input wire logic                     i_power_key_n,
  input wire btnev_pkg::btnev_sys_type i_sys_state,
  input wire logic                     i_power_key_status_clr,
  input wire logic                     i_sleep_key_status_clr,
  input wire logic                     o_power_key_status_flag,
  input wire logic                     o_sleep_key_status_flag,
  input wire logic                     o_system_control_interrupt,
  input wire logic                     o_wake,
  input wire logic                     o_power_key_override_signal
);
  import btnev_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // eight quiet cycles outlast the synchroniser, so no late press can land
  sequence key_idle_s;
    i_power_key_n [*8];
  endsequence
  // override pulse with the flag already gone, then silence
  sequence ovr_done_s;
    !o_power_key_status_flag ##1 !o_power_key_override_signal;
  endsequence
  idle_no_press_a: assert property (
    key_idle_s |-> !$rose(o_power_key_status_flag)) else $error("press while idle");
  sci_has_cause_a: assert property (
    o_system_control_interrupt |-> o_power_key_status_flag || o_sleep_key_status_flag
    || $past(o_power_key_status_flag || o_sleep_key_status_flag)) else $error("stray sci");
  pwr_sticky_a: assert property (
    $fell(o_power_key_status_flag) |-> $past(i_power_key_status_clr)
    || o_power_key_override_signal) else $error("power flag lost");
  slp_sticky_a: assert property (
    $fell(o_sleep_key_status_flag) |-> $past(i_sleep_key_status_clr))
    else $error("sleep flag lost");
  ovr_clears_a: assert property (
    o_power_key_override_signal |-> ovr_done_s) else $error("override shape");
  ovr_working_a: assert property (
    o_power_key_override_signal |-> $past(i_sys_state) == BTNEV_WORKING) else $error("ovr state");
  wake_pulse_a: assert property (
    o_wake |=> !o_wake) else $error("wake too long");
  wake_asleep_a: assert property (
    o_wake |-> $past(i_sys_state) != BTNEV_WORKING) else $error("wake while working");
endmodule : btnev_top_asserts

bind btnev_top btnev_top_asserts chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_power_key_n(i_power_key_n), .i_sys_state(i_sys_state),
  .i_power_key_status_clr(i_power_key_status_clr),
  .i_sleep_key_status_clr(i_sleep_key_status_clr),
  .o_power_key_status_flag(o_power_key_status_flag),
  .o_sleep_key_status_flag(o_sleep_key_status_flag),
  .o_system_control_interrupt(o_system_control_interrupt), .o_wake(o_wake),
  .o_power_key_override_signal(o_power_key_override_signal));

// ### test/tb_button_event_logic.sv
/* tb_button_event_logic: self-checking bench for btnev_top.
   assumes: shortened tick, debounce and override counts; keys from btnev_keys_model. */
`timescale 1ns/10ps
module tb_button_event_logic;
  import btnev_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pdown = 1'b0, sdown = 1'b0, bounce = 1'b0, wr = 1'b0;
  logic pen = 1'b0, sen = 1'b0, pclr = 1'b0, sclr = 1'b0, trig = 1'b0;
  logic pkey_n, skey_n, pflag, sflag, system_control_interrupt, gpe, wake, ovr;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, r = 8'h32;
  btnev_sys_type state = BTNEV_WORKING;
  int miscompares = 0, check_count = 0, wake_cnt = 0, ovr_cnt = 0;
  btnev_keys_model keys_u (.i_clk(clk), .i_power_down(pdown), .i_sleep_down(sdown),
    .i_bounce(bounce), .o_power_key_n(pkey_n), .o_sleep_key_n(skey_n));
  btnev_top #(.TICK_CYCLES(4), .DEBOUNCE_TKS(2), .OVERRIDE_TKS(10)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_power_key_n(pkey_n), .i_sleep_key_n(skey_n),
    .i_sys_state(state), .i_power_key_enable_flag(pen), .i_sleep_key_enable_flag(sen),
    .i_power_key_status_clr(pclr), .i_sleep_key_status_clr(sclr),
    .i_sleep_entry_trigger(trig), .i_io_addr(addr), .i_io_wr(wr), .i_io_wdata(wdata),
    .o_io_rdata(rdata), .o_power_key_status_flag(pflag), .o_sleep_key_status_flag(sflag),
    .o_system_control_interrupt(system_control_interrupt), .o_gpe0_status_bit0(gpe), .o_wake(wake),
    .o_power_key_override_signal(ovr));
  initial begin
    forever #10 clk = ~clk;
  end
  // both pulses stand one cycle, so count them where they happen
  always @(posedge clk) begin
    wake_cnt <= wake_cnt + int'(wake === 1'b1);
    ovr_cnt <= ovr_cnt + int'(ovr === 1'b1);
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic exp_wake(input logic pwr, input btnev_sys_type st, input logic tr);
    return pwr ? st != BTNEV_WORKING : st == BTNEV_SLEEPING && tr;
  endfunction : exp_wake
  // method event handler: a set press bit notifies 0x80, a set wake bit 0x2
  function automatic logic [7:0] notify_code(input logic [7:0] b);
    return b[PRESS_REQ_POS] ? 8'h80 : (b[WAKE_REQ_POS] ? 8'h02 : 8'h00);
  endfunction : notify_code
  // read data is registered, so it is looked at a cycle after the strobe
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    addr = a;
    wr = w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : io
  // hold a key until its flag shows (bounded) and for hold more cycles, then release and let it settle
  task automatic press(input logic pwr, input int hold);
    int n;
    pdown = pwr;
    sdown = !pwr;
    for (n = 0; (pwr ? pflag : sflag) !== 1'b1 && n < 80; n++) @(negedge clk);
    if (n == 80) begin
      miscompares++;
      report_and_stop();
    end
    repeat (hold) @(negedge clk);
    {pdown, sdown} = 2'b00;
    repeat (40) @(negedge clk);
  endtask : press
  task automatic run(input logic pwr, input btnev_sys_type st, input logic en, input logic tr,
                     input logic bnc);
    int w0;
    logic [7:0] mb;
    w0 = wake_cnt;
    mb = {6'h00, pwr && st != BTNEV_WORKING, pwr && st == BTNEV_WORKING};
    state = st;
    {pen, sen, trig, bounce} = {en, en, tr, bnc};
    press(pwr, 10);
    check(8'(pwr ? pflag : sflag), 8'h01);
    check(8'(system_control_interrupt), 8'(en && st == BTNEV_WORKING));
    check(8'(wake_cnt - w0), 8'(exp_wake(pwr, st, tr)));
    io(16'h0201, 1'b0, 8'h00);
    check(rdata, 8'h00);
    io(METHOD_BYTE_ADDR, 1'b0, 8'h00);
    check(rdata, mb);
    check(notify_code(rdata), pwr ? (st == BTNEV_WORKING ? 8'h80 : 8'h02) : 8'h00);
    io(METHOD_BYTE_ADDR, 1'b1, 8'h01);
    check({rdata[7:1], gpe}, {mb[7:1], mb[1]});
    io(METHOD_BYTE_ADDR, 1'b1, 8'h02);
    check(rdata, 8'h00);
    {pclr, sclr} = 2'b11;
    @(negedge clk);
    {pclr, sclr} = 2'b00;
    @(negedge clk);
    check(8'({pflag, sflag, system_control_interrupt}), 8'h00);
  endtask : run
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({2'b00, pflag, sflag, system_control_interrupt, gpe, wake, ovr}, 8'h00);
    check(rdata, METHOD_BYTE_RESET);
    run(1'b1, BTNEV_WORKING, 1'b1, 1'b0, 1'b0);
    run(1'b1, BTNEV_WORKING, 1'b0, 1'b0, 1'b1);
    run(1'b0, BTNEV_WORKING, 1'b1, 1'b0, 1'b0);
    run(1'b1, BTNEV_SLEEPING, 1'b0, 1'b0, 1'b1);
    run(1'b1, BTNEV_SOFT_OFF, 1'b0, 1'b0, 1'b0);
    run(1'b0, BTNEV_SLEEPING, 1'b1, 1'b0, 1'b0);
    run(1'b0, BTNEV_SLEEPING, 1'b0, 1'b1, 1'b1);
    // two short holds keep the flag and must not add up; the long one hits the override
    state = BTNEV_WORKING;
    {pen, sen, trig, bounce} = 4'b1000;
    repeat (2) press(1'b1, 20);
    check(8'({pflag, ovr_cnt[0]}), 8'h02);
    press(1'b1, 90);
    check(8'({pflag, system_control_interrupt, ovr_cnt[1:0]}), 8'h01);
    io(METHOD_BYTE_ADDR, 1'b1, 8'h03);
    repeat (8) begin
      r = lfsr(r);
      run(r[0], r[2] ? BTNEV_SLEEPING : (r[1] ? BTNEV_SOFT_OFF : BTNEV_WORKING),
          r[3], r[4], r[5]);
    end
    report_and_stop();
  end
endmodule : tb_button_event_logic
